//--- include/group_select_pkg.sv
package group_select_pkg;

  // ****************************************************************
  // group numbering
  // ****************************************************************
  localparam int unsigned NUM_GROUPS = 6;
  localparam logic [2:0]  GROUP_MIN  = 3'h1;
  localparam logic [2:0]  GROUP_MAX  = 3'h6;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_PULSE  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL_SEL_LSB    = 0;
  localparam int unsigned CTRL_MAX_LSB    = 8;
  localparam int unsigned PULSE_LEN_LSB   = 0;
  localparam int unsigned STAT_GROUP_LSB  = 0;
  localparam int unsigned STAT_BUSY_BIT   = 8;
  localparam int unsigned STAT_INPUTS_LSB = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] RST_SELECTED  = 3'h1;
  localparam logic [2:0] RST_MAX_COUNT = 3'h1;
  localparam logic [6:0] RST_PULSE_LEN = 7'h0a;
  localparam logic [5:0] RST_ACTIVE_OH = 6'h01;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned PULSE_STEP_MS  = 100;
  localparam logic [6:0]  PULSE_LEN_MAX  = 7'h64;
  localparam int unsigned STEP_CYCLES    =
    (PULSE_STEP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : group_select_pkg

//--- rtl/change_pulse_timer.sv
`timescale 1ns/100ps
module change_pulse_timer #(
  parameter int unsigned STEP_CYCLES = group_select_pkg::STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [6:0] lenSteps,
  output logic            pulseOut
);

  localparam int unsigned CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] LAST_STEP = CW'(STEP_CYCLES - 1);

  generate
    if (STEP_CYCLES < 1)
    begin : g_bad_step
      $error("STEP_CYCLES must be at least one");
    end
  endgenerate

  logic [CW-1:0] stepCnt_q;
  logic [6:0]    stepsLeft_q;
  logic          busy_q;

  // ****************************************************************
  // step divider: one-cycle enable every 0.1 s while busy
  // ****************************************************************
  wire tick     = busy_q && (stepCnt_q == LAST_STEP);
  wire finished = busy_q && ((stepsLeft_q == 7'h00) ||
                  (tick && (stepsLeft_q == 7'h01)));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stepCnt_q   <= '0;
      stepsLeft_q <= 7'h00;
      busy_q      <= 1'b0;
    end
    else if (start)
    begin
      // a new change restarts the full length
      stepCnt_q   <= '0;
      stepsLeft_q <= lenSteps;
      busy_q      <= 1'b1;
    end
    else if (finished)
    begin
      busy_q      <= 1'b0;
    end
    else if (busy_q)
    begin
      stepCnt_q   <= tick ? '0 : stepCnt_q + CW'(1);
      stepsLeft_q <= tick ? stepsLeft_q - 7'h01 : stepsLeft_q;
    end
  end

  assign pulseOut = busy_q;

endmodule : change_pulse_timer

//--- rtl/group_select_unit.sv
`timescale 1ns/100ps
module group_select_unit #(
  parameter int unsigned STEP_CYCLES = group_select_pkg::STEP_CYCLES,
  parameter int unsigned ADDR_W      = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              select_group_one_in,
  input  wire logic              select_group_two_in,
  input  wire logic              select_group_three_in,
  input  wire logic              select_group_four_in,
  input  wire logic              select_group_five_in,
  input  wire logic              select_group_six_in,
  output logic                   group_one_active_out,
  output logic                   group_two_active_out,
  output logic                   group_three_active_out,
  output logic                   group_four_active_out,
  output logic                   group_five_active_out,
  output logic                   group_six_active_out,
  output logic                   group_changed_pulse,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr
);

  generate
    if (ADDR_W < 12)
    begin : g_bad_addr
      $error("ADDR_W must be at least 12");
    end
  endgenerate

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic [5:0] lowest_one_hot(input logic [5:0] req);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 5; i >= 0; i--)
    begin
      if (req[i])
      begin
        res = 6'h00;
        res[i] = 1'b1;
      end
    end
    return res;
  endfunction : lowest_one_hot

  function automatic logic [5:0] group_to_one_hot(input logic [2:0] grp);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      if (grp == 3'(i + 1))
      begin
        res[i] = 1'b1;
      end
    end
    return res;
  endfunction : group_to_one_hot

  function automatic logic [2:0] one_hot_to_group(input logic [5:0] oh);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      if (oh[i])
      begin
        res = 3'(i + 1);
      end
    end
    return res;
  endfunction : one_hot_to_group

  function automatic logic group_in_range(input logic [2:0] grp);
    return (grp >= group_select_pkg::GROUP_MIN) &&
           (grp <= group_select_pkg::GROUP_MAX);
  endfunction : group_in_range

  // ****************************************************************
  // state
  // ****************************************************************
  logic [5:0] activeOh_q;
  logic [5:0] activeOh_d;
  logic [2:0] selected_group_setting_q;
  logic [2:0] selected_group_setting_d;
  logic [2:0] max_group_count_q;
  logic [2:0] max_group_count_d;
  logic [6:0] pulseLen_q;
  logic [6:0] pulseLen_d;
  logic       settingApply;
  logic       pulseBusy;

  // bus response: setup, one wait cycle, then the answer cycle
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } busState_t;

  busState_t   busState_q;
  busState_t   busState_d;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic        slvErr_q;
  logic        slvErr_d;

  // ****************************************************************
  // select inputs
  // ****************************************************************
  // undriven selects are tied low at the instance by the integrator
  wire [5:0] selectIn = {select_group_six_in,
                         select_group_five_in,
                         select_group_four_in,
                         select_group_three_in,
                         select_group_two_in,
                         select_group_one_in};

  logic [5:0] allowedMask;
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_allowed
      assign allowedMask[g] = (3'(g + 1) <= max_group_count_q);
    end
  endgenerate

  wire [5:0] validReq  = selectIn & allowedMask;
  wire       anyReq    = |validReq;
  wire [5:0] winnerOh  = lowest_one_hot(validReq);
  wire       outOfRange = |(activeOh_q & ~allowedMask);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire [11:0] addrLow   = paddr[11:0];
  wire        upperZero = (ADDR_W == 12) ? 1'b1 :
                          ~|(paddr >> 12);
  wire        hitCtrl   = upperZero &&
                          (addrLow == group_select_pkg::ADDR_CTRL);
  wire        hitPulse  = upperZero &&
                          (addrLow == group_select_pkg::ADDR_PULSE);
  wire        hitStatus = upperZero &&
                          (addrLow == group_select_pkg::ADDR_STATUS);
  wire        access    = psel && penable;
  wire        answer    = (busState_q == BUS_ANSWER);
  wire        capture   = access && !answer;
  wire        wrAccess  = access && answer && pwrite;
  wire        wrCtrl    = wrAccess && hitCtrl;
  wire        wrPulse   = wrAccess && hitPulse && pstrb[0];
  wire        badAccess = access && !(hitCtrl || hitPulse ||
                          (hitStatus && !pwrite));

  wire [2:0] wrSelField = pwdata[group_select_pkg::CTRL_SEL_LSB +: 3];
  wire [2:0] wrMaxField = pwdata[group_select_pkg::CTRL_MAX_LSB +: 3];
  wire [6:0] wrLenField = pwdata[group_select_pkg::PULSE_LEN_LSB +: 7];

  // ****************************************************************
  // configuration writes
  // ****************************************************************
  // out-of-range group numbers and counts leave the field unchanged
  assign max_group_count_d =
    (wrCtrl && pstrb[1] && group_in_range(wrMaxField)) ?
    wrMaxField : max_group_count_q;

  assign selected_group_setting_d =
    (wrCtrl && pstrb[0] && group_in_range(wrSelField)) ?
    wrSelField : selected_group_setting_q;

  // a written selection only switches when allowed by the new maximum
  assign settingApply = wrCtrl && pstrb[0] &&
                        group_in_range(wrSelField) &&
                        (wrSelField <= max_group_count_d);

  assign pulseLen_d = !wrPulse ? pulseLen_q :
    (wrLenField > group_select_pkg::PULSE_LEN_MAX) ?
    group_select_pkg::PULSE_LEN_MAX : wrLenField;

  // ****************************************************************
  // active group resolution
  // ****************************************************************
  // a held select input within the maximum beats software; a lowered maximum falls back
  // to group one so exactly one group stays active
  assign activeOh_d = anyReq       ? winnerOh :
                      settingApply ? group_to_one_hot(wrSelField) :
                      outOfRange   ? group_select_pkg::RST_ACTIVE_OH :
                      activeOh_q;

  wire groupChanged = (activeOh_d != activeOh_q);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      activeOh_q               <= group_select_pkg::RST_ACTIVE_OH;
      selected_group_setting_q <= group_select_pkg::RST_SELECTED;
      max_group_count_q        <= group_select_pkg::RST_MAX_COUNT;
      pulseLen_q               <= group_select_pkg::RST_PULSE_LEN;
    end
    else
    begin
      activeOh_q               <= activeOh_d;
      selected_group_setting_q <= selected_group_setting_d;
      max_group_count_q        <= max_group_count_d;
      pulseLen_q               <= pulseLen_d;
    end
  end

  // ****************************************************************
  // changed pulse
  // ****************************************************************
  change_pulse_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_pulse (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (groupChanged),
    .lenSteps (pulseLen_q),
    .pulseOut (pulseBusy)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign group_one_active_out   = activeOh_q[0];
  assign group_two_active_out   = activeOh_q[1];
  assign group_three_active_out = activeOh_q[2];
  assign group_four_active_out  = activeOh_q[3];
  assign group_five_active_out  = activeOh_q[4];
  assign group_six_active_out   = activeOh_q[5];
  assign group_changed_pulse    = pulseBusy;

  // ****************************************************************
  // apb read path
  // ****************************************************************
  logic [31:0] ctrlWord;
  logic [31:0] pulseWord;
  logic [31:0] statusWord;

  always_comb
  begin
    ctrlWord   = 32'h0000_0000;
    pulseWord  = 32'h0000_0000;
    statusWord = 32'h0000_0000;
    ctrlWord[group_select_pkg::CTRL_SEL_LSB +: 3] =
      selected_group_setting_q;
    ctrlWord[group_select_pkg::CTRL_MAX_LSB +: 3] = max_group_count_q;
    pulseWord[group_select_pkg::PULSE_LEN_LSB +: 7] = pulseLen_q;
    statusWord[group_select_pkg::STAT_GROUP_LSB +: 3] =
      one_hot_to_group(activeOh_q);
    statusWord[group_select_pkg::STAT_BUSY_BIT] = pulseBusy;
    statusWord[group_select_pkg::STAT_INPUTS_LSB +: 6] = selectIn;
  end

  wire [31:0] readMux = hitCtrl   ? ctrlWord :
                        hitPulse  ? pulseWord :
                        hitStatus ? statusWord :
                        32'h0000_0000;

  // ****************************************************************
  // apb response
  // ****************************************************************
  // read data and error are captured in the first access cycle and
  // shown in the second, so the read path stays registered
  always_comb
  begin
    busState_d = busState_q;
    case (busState_q)
      BUS_IDLE:
      begin
        if (capture)
        begin
          busState_d = BUS_ANSWER;
        end
      end
      BUS_ANSWER:
      begin
        busState_d = BUS_IDLE;
      end
      default:
      begin
        busState_d = BUS_IDLE;
      end
    endcase
  end

  assign rdData_d = (capture && !pwrite) ? readMux : 32'h0000_0000;
  assign slvErr_d = capture && badAccess;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busState_q <= BUS_IDLE;
      rdData_q   <= 32'h0000_0000;
      slvErr_q   <= 1'b0;
    end
    else
    begin
      busState_q <= busState_d;
      rdData_q   <= rdData_d;
      slvErr_q   <= slvErr_d;
    end
  end

  assign pready  = answer;
  assign pslverr = slvErr_q;
  assign prdata  = rdData_q;

endmodule : group_select_unit

//--- tb/group_select_properties.sv
`timescale 1ns/100ps
module group_select_checker #(
  parameter int unsigned STEP_CYCLES = 4,
  parameter int unsigned ADDR_W      = 12
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              select_group_one_in,
  input wire logic              select_group_two_in,
  input wire logic              select_group_three_in,
  input wire logic              select_group_four_in,
  input wire logic              select_group_five_in,
  input wire logic              select_group_six_in,
  input wire logic              group_one_active_out,
  input wire logic              group_two_active_out,
  input wire logic              group_three_active_out,
  input wire logic              group_four_active_out,
  input wire logic              group_five_active_out,
  input wire logic              group_six_active_out,
  input wire logic              group_changed_pulse,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  // ****
  // helpers
  // ****
  localparam logic [11:0] ST = group_select_pkg::ADDR_STATUS;
  logic [5:0] sel;
  logic [5:0] act;
  assign sel = {select_group_six_in, select_group_five_in,
    select_group_four_in, select_group_three_in,
    select_group_two_in, select_group_one_in};
  assign act = {group_six_active_out, group_five_active_out,
    group_four_active_out, group_three_active_out,
    group_two_active_out, group_one_active_out};
  // number of the lowest set bit, 7 when none
  function automatic int unsigned num(input logic [5:0] v);
    for (int i = 0; i < 6; i++)
      if (v[i])
        return i + 1;
    return 7;
  endfunction : num
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_onehot; $onehot(act); endproperty
  a_onehot: assert property (p_onehot)
    else $error("active group not one-hot");
  property p_reset; $rose(rst_n) |-> act == 6'h01 && !group_changed_pulse;
  endproperty
  a_reset: assert property (p_reset)
    else $error("wrong state after reset");
  property p_one; select_group_one_in |=> group_one_active_out; endproperty
  a_one: assert property (p_one)
    else $error("group one request not honoured");
  property p_low; |sel |=> num(act) <= num($past(sel)); endproperty
  a_low: assert property (p_low)
    else $error("active group above lowest request");
  property p_chg; !$stable(act) |-> group_changed_pulse; endproperty
  a_chg: assert property (p_chg)
    else $error("group change without pulse");
  property p_cause; $rose(group_changed_pulse) |-> !$stable(act); endproperty
  a_cause: assert property (p_cause)
    else $error("pulse without group change");
  property p_stat;
    psel && penable && pready && !pwrite && paddr == ST |->
      prdata[2:0] == num($past(act)) && !pslverr;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status does not show active group");
  property p_wrst;
    psel && penable && pready && pwrite && paddr == ST |-> pslverr;
  endproperty
  a_wrst: assert property (p_wrst)
    else $error("status write not refused");
  property p_unmap; psel && penable && pready && paddr > ST |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  cover property (select_group_two_in && select_group_four_in);
  cover property ($rose(group_six_active_out));
  cover property (psel && penable && pslverr);
endmodule : group_select_checker

bind group_select_unit group_select_checker #(
  .STEP_CYCLES(STEP_CYCLES), .ADDR_W(ADDR_W)) props_i (.clk, .rst_n,
  .select_group_one_in, .select_group_two_in, .select_group_three_in,
  .select_group_four_in, .select_group_five_in, .select_group_six_in,
  .group_one_active_out, .group_two_active_out, .group_three_active_out,
  .group_four_active_out, .group_five_active_out, .group_six_active_out,
  .group_changed_pulse, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .pready);

//--- tb/select_source.sv
`timescale 1ns/100ps
module select_source #(
  parameter int unsigned HOLD = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [5:0] mask,
  output logic      [5:0] sel
);
  // ****
  // request pulse generator
  // ****
  logic [5:0]  holdMask_q;
  int unsigned left_q;
  // hold stands for a pulse of 200 ms at reduced scale
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      left_q <= 0;
    else if (go)
      left_q <= HOLD;
    else if (left_q != 0)
      left_q <= left_q - 1;
    if (go)
      holdMask_q <= mask;
  end
  assign sel = (left_q != 0) ? holdMask_q : 6'h00;
endmodule : select_source

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // ****
  // signals
  // ****
  localparam int unsigned STEP = 4;
  localparam int unsigned PLEN = group_select_pkg::RST_PULSE_LEN * STEP;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'hf;
  logic        go      = 1'b0;
  logic [5:0]  mask    = 6'h00;
  logic        pready;
  logic        pslverr;
  logic        pulse;
  logic        err;
  logic [31:0] prdata;
  logic [31:0] rd;
  wire  [5:0]  sel;
  wire  [5:0]  act;
  int          failures = 0;
  int          checks   = 0;

  group_select_unit #(.STEP_CYCLES(STEP)) uut (.clk(clk), .rst_n(rst_n),
    .select_group_one_in(sel[0]), .select_group_two_in(sel[1]),
    .select_group_three_in(sel[2]), .select_group_four_in(sel[3]),
    .select_group_five_in(sel[4]), .select_group_six_in(sel[5]),
    .group_one_active_out(act[0]), .group_two_active_out(act[1]),
    .group_three_active_out(act[2]), .group_four_active_out(act[3]),
    .group_five_active_out(act[4]), .group_six_active_out(act[5]),
    .group_changed_pulse(pulse), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  select_source src (.clk(clk), .rst_n(rst_n), .go(go), .mask(mask),
    .sel(sel));

  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pick(input logic [5:0] m);
    @(posedge clk);
    go   <= 1'b1;
    mask <= m;
    @(posedge clk);
    go <= 1'b0;
  endtask : pick

  // counts cycles of the change pulse, zero if none comes
  task automatic measure(input int unsigned len);
    int unsigned n;
    n = 0;
    @(negedge clk);
    repeat (20)
      if (pulse !== 1'b1)
        @(negedge clk);
    while (pulse === 1'b1 && n < 1000)
    begin
      n++;
      @(negedge clk);
    end
    chk(n, len);
  endtask : measure

  task automatic close_out();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // ****
  // clock, watchdog and tests
  // ****
  initial
  begin
    forever
      #10 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, group_select_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0101);
    chk({26'h0, act}, 32'h0000_0001);
    apb(1'b0, group_select_pkg::ADDR_PULSE, 32'h0000_0000);
    chk(rd, 32'h0000_000a);
    pick(6'h02);
    measure(0);
    chk({26'h0, act}, 32'h0000_0001);
    apb(1'b1, group_select_pkg::ADDR_CTRL, 32'h0000_0601);
    pick(6'h0a);
    measure(PLEN);
    chk({26'h0, act}, 32'h0000_0002);
    for (int i = 0; i < 6; i++)
    begin
      pick(6'h01 << i);
      measure(PLEN);
      chk({26'h0, act}, 32'h0000_0001 << i);
    end
    apb(1'b1, group_select_pkg::ADDR_PULSE, 32'h0000_0000);
    apb(1'b1, group_select_pkg::ADDR_CTRL, 32'h0000_0605);
    measure(1);
    chk({26'h0, act}, 32'h0000_0010);
    apb(1'b1, group_select_pkg::ADDR_PULSE, 32'h0000_007f);
    apb(1'b0, group_select_pkg::ADDR_PULSE, 32'h0000_0000);
    chk(rd, 32'h0000_0064);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, group_select_pkg::ADDR_STATUS, 32'h0000_0003);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, group_select_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    close_out();
  end
endmodule : tb_top
